// *** hw/wdrt_pkg.sv ***
package wdrt_pkg;

  // register offsets inside the clock chip window (byte wide)
  localparam logic [3:0] OFS_CMD   = 4'hB;
  localparam logic [3:0] OFS_TOLO  = 4'hC;   // hundredths and tenths digits
  localparam logic [3:0] OFS_TOHI  = 4'hD;   // tens and units of seconds

  // command byte field positions
  localparam int CMD_FLAG   = 1;
  localparam int CMD_EN     = 3;
  localparam int CMD_PULSE  = 4;
  localparam int CMD_POL    = 5;
  localparam int CMD_SEL    = 6;
  localparam int CMD_XFER   = 7;
  localparam logic [7:0] CMD_RW_MASK = 8'hFA;  // bits 0 and 2 unused
  localparam logic [7:0] CMD_RST     = 8'h00;
  localparam logic [7:0] TO_RST      = 8'h00;

  // board control register layout
  localparam int BCR_WDEN = 0;
  localparam logic [7:0] BCR_RST = 8'h00;

  // timing: clock rate, count step, halt-to-reset delay, reset hold
  localparam int CLK_KHZ      = 125000;
  localparam int STEP_TIME_MS = 10;
  localparam int HALT_TIME_MS = 300;
  localparam int STEP_CYC     = STEP_TIME_MS * CLK_KHZ;
  localparam int HALT_CYC     = HALT_TIME_MS * CLK_KHZ;
  localparam int RST_HOLD_CYC = 16;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_WAIT = 3'b010,
    ST_RST  = 3'b100
  } wdrt_state_t;

endpackage

// *** hw/wdrt_count_if.sv ***
`timescale 1ns/1ps
// carries load, step and count value between sequencer and counter
interface wdrt_count_if;
  logic        load;
  logic [15:0] loadVal;
  logic        step;
  logic [15:0] value;
  logic        zero;

  modport owner   (output load, loadVal, step, input value, zero);
  modport counter (input load, loadVal, step, output value, zero);
endinterface

// *** hw/wdrt_step_div.sv ***
`timescale 1ns/1ps
// divides mclk down to a one-cycle enable every STEP_CYC cycles
module wdrt_step_div #(
  parameter int STEP_CYC = wdrt_pkg::STEP_CYC
) (
  input  wire logic mclk,     // system clock
  input  wire logic rst,      // async reset, active high
  input  wire logic restart,  // restart a full period
  output logic      step      // one-cycle step enable
);
  logic [31:0] divCnt_r;
  wire         wrap = (divCnt_r == 32'(STEP_CYC - 1));

  // free counter, restarted on every reload so the first step is full length
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_r <= 32'h0;
      step     <= 1'b0;
    end else begin
      divCnt_r <= (restart || wrap) ? 32'h0 : divCnt_r + 32'h1;
      step     <= wrap && !restart;
    end
  end
endmodule

// *** hw/wdrt_bcd_count.sv ***
`timescale 1ns/1ps
// four-digit bcd down counter that holds at zero
module wdrt_bcd_count (
  input wire logic   mclk,  // system clock
  input wire logic   rst,   // async reset, active high
  wdrt_count_if.counter cif // load, step and value
);
  logic [15:0] val_r;

  // one bcd step down, borrowing through all four digits
  function automatic logic [15:0] bcdDec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (v[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
          borrow      = 1'b0;
        end
      end
    end
    return r;
  endfunction

  assign cif.value = val_r;
  assign cif.zero  = (val_r == 16'h0000);

  // reload wins over a step; zero holds without wrapping
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      val_r <= 16'h0000;
    end else if (cif.load) begin
      val_r <= cif.loadVal;
    end else if (cif.step && !cif.zero) begin
      val_r <= bcdDec(val_r);
    end
  end
endmodule

// *** hw/wdrt_top.sv ***
`timescale 1ns/1ps
module wdrt_top #(
  parameter int STEP_CYC = wdrt_pkg::STEP_CYC,  // cycles per hundredth of a second
  parameter int HALT_CYC = wdrt_pkg::HALT_CYC   // cycles from halt to board reset
) (
  input  wire logic       mclk,       // 125 MHz clock
  input  wire logic       rst,        // async reset, active high
  input  wire logic       busSel,     // clock chip access strobe
  input  wire logic       busWr,      // 1 write, 0 read
  input  wire logic [3:0] busAddr,    // byte offset in chip window
  input  wire logic [7:0] busWdata,   // write data
  output logic      [7:0] busRdata,   // read data, next cycle
  input  wire logic       ctlWr,      // board control write strobe
  input  wire logic [7:0] ctlWdata,   // board control write data
  output logic      [7:0] ctlRdata,   // board control contents
  input  wire logic       causeClr,   // clear reset-cause bit
  output logic            causeWdog,  // last reset came from watchdog
  output logic            haltReq,    // one-cycle halt request
  output logic            boardReset, // board hardware reset
  output logic            wdIrqA,     // interrupt line a
  output logic            wdIrqB      // interrupt line b
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0]            cmd_r;
  logic [7:0]            toLo_r;
  logic [7:0]            toHi_r;
  logic [7:0]            bcr_r;
  logic                  armed_r;
  logic                  cause_r;
  wdrt_pkg::wdrt_state_t state_r;
  wdrt_pkg::wdrt_state_t state_nxt;
  logic [31:0]           delay_r;
  logic [31:0]           delay_nxt;
  logic [7:0]            rdata_nxt;
  logic                  pulseIrq_r;

  wdrt_count_if cif ();

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire hitCmd   = busSel && (busAddr == wdrt_pkg::OFS_CMD);
  wire hitLo    = busSel && (busAddr == wdrt_pkg::OFS_TOLO);
  wire hitHi    = busSel && (busAddr == wdrt_pkg::OFS_TOHI);
  wire hitAny   = hitCmd || hitLo || hitHi;
  wire wrCmd    = hitCmd && busWr;
  wire wrLo     = hitLo && busWr;
  wire wrHi     = hitHi && busWr;

  // command byte fields
  wire wdOn     = cmd_r[wdrt_pkg::CMD_EN];
  wire pulseMd  = cmd_r[wdrt_pkg::CMD_PULSE];
  wire polHigh  = cmd_r[wdrt_pkg::CMD_POL];
  wire selB     = cmd_r[wdrt_pkg::CMD_SEL];
  wire flag     = cmd_r[wdrt_pkg::CMD_FLAG];
  wire boardEn  = bcr_r[wdrt_pkg::BCR_WDEN];

  // timeout image as the counter sees it, after this cycle's writes
  wire [7:0]  newLo   = wrLo ? busWdata : toLo_r;
  wire [7:0]  newHi   = wrHi ? busWdata : toHi_r;
  wire [15:0] newTo   = {newHi, newLo};

  // ---------------------------------------------------------------
  // counter hookup
  // ---------------------------------------------------------------
  // any access to the command or timeout bytes, read or write, restores the programmed timeout
  assign cif.load    = hitAny;
  assign cif.loadVal = newTo;

  wdrt_step_div #(
    .STEP_CYC (STEP_CYC)
  ) u_div (
    .mclk    (mclk),
    .rst     (rst),
    .restart (hitAny),
    .step    (cif.step)
  );

  wdrt_bcd_count u_cnt (
    .mclk (mclk),
    .rst  (rst),
    .cif  (cif)
  );

  // expiry: armed, enabled and the count has run out
  wire expire   = armed_r && wdOn && cif.zero && !hitAny;
  wire inRun    = (state_r == wdrt_pkg::ST_RUN);
  wire fire     = expire && inRun;
  wire delayEnd = (delay_r == 32'h0);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (hitCmd) begin
      rdata_nxt = cmd_r & wdrt_pkg::CMD_RW_MASK;
    end else if (hitLo) begin
      rdata_nxt = toLo_r;
    end else if (hitHi) begin
      rdata_nxt = toHi_r;
    end
  end

  // read data returns one cycle after the strobe; zero otherwise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busRdata <= 8'h00;
    end else begin
      busRdata <= (busSel && !busWr) ? rdata_nxt : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // timeout registers
  // ---------------------------------------------------------------
  // two bcd bytes, stored as written
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      toLo_r <= wdrt_pkg::TO_RST;
      toHi_r <= wdrt_pkg::TO_RST;
    end else begin
      toLo_r <= newLo;
      toHi_r <= newHi;
    end
  end

  // ---------------------------------------------------------------
  // command byte
  // ---------------------------------------------------------------
  // software writes the rw fields; expiry sets the flag and wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_r <= wdrt_pkg::CMD_RST;
    end else begin
      if (wrCmd) begin
        cmd_r <= busWdata & wdrt_pkg::CMD_RW_MASK;
      end
      if (fire) begin
        cmd_r[wdrt_pkg::CMD_FLAG] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // arming
  // ---------------------------------------------------------------
  // a reload with a nonzero timeout arms; expiry disarms until reload
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b0;
    end else if (hitAny) begin
      armed_r <= (newTo != 16'h0000);
    end else if (fire) begin
      armed_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // board control register
  // ---------------------------------------------------------------
  // comes up cleared; the board reset clears it again
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bcr_r <= wdrt_pkg::BCR_RST;
    end else if (state_r == wdrt_pkg::ST_RST) begin
      bcr_r <= wdrt_pkg::BCR_RST;
    end else if (ctlWr) begin
      bcr_r <= ctlWdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctlRdata <= wdrt_pkg::BCR_RST;
    end else begin
      ctlRdata <= bcr_r;
    end
  end

  // ---------------------------------------------------------------
  // halt then reset sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    delay_nxt = delay_r;
    case (state_r)
      wdrt_pkg::ST_RUN: begin
        if (fire) begin
          state_nxt = wdrt_pkg::ST_WAIT;
          delay_nxt = 32'(HALT_CYC - 1);
        end
      end
      wdrt_pkg::ST_WAIT: begin
        if (!delayEnd) begin
          delay_nxt = delay_r - 32'h1;
        end else if (boardEn) begin
          state_nxt = wdrt_pkg::ST_RST;
          delay_nxt = 32'(wdrt_pkg::RST_HOLD_CYC - 1);
        end else begin
          state_nxt = wdrt_pkg::ST_RUN;
        end
      end
      wdrt_pkg::ST_RST: begin
        if (!delayEnd) begin
          delay_nxt = delay_r - 32'h1;
        end else begin
          state_nxt = wdrt_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = wdrt_pkg::ST_RUN;
        delay_nxt = 32'h0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= wdrt_pkg::ST_RUN;
      delay_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      delay_r <= delay_nxt;
    end
  end

  // halt pulse and board reset, both from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      haltReq    <= 1'b0;
      boardReset <= 1'b0;
    end else begin
      haltReq    <= fire;
      boardReset <= (state_nxt == wdrt_pkg::ST_RST);
    end
  end

  // ---------------------------------------------------------------
  // reset cause
  // ---------------------------------------------------------------
  // set when the watchdog resets the board; set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cause_r <= 1'b0;
    end else if (state_nxt == wdrt_pkg::ST_RST) begin
      cause_r <= 1'b1;
    end else if (causeClr) begin
      cause_r <= 1'b0;
    end
  end

  assign causeWdog = cause_r;

  // ---------------------------------------------------------------
  // interrupt lines
  // ---------------------------------------------------------------
  // pulse mode: one cycle at expiry; level mode: follows the flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulseIrq_r <= 1'b0;
    end else begin
      pulseIrq_r <= pulseMd ? fire : (flag || fire);
    end
  end

  // selected line carries the event at the chosen polarity
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdIrqA <= 1'b1;                                       // idle level of the active-low default
      wdIrqB <= 1'b1;                                       // idle level of the active-low default
    end else begin
      wdIrqA <= (!selB && pulseIrq_r) ? polHigh : !polHigh;
      wdIrqB <= (selB && pulseIrq_r) ? polHigh : !polHigh;
    end
  end

endmodule

// *** tb/wdrt_top_sva.sv ***
`timescale 1ns/1ps
// watches the top ports for read, halt, interrupt and reset timing
module wdrt_top_sva #(
  parameter int STEP_CYC = 20,  // cycles per count step
  parameter int HALT_CYC = 50   // cycles from halt to reset
) (
  input wire logic       mclk,       // clock
  input wire logic       rst,        // async reset
  input wire logic       busSel,     // access strobe
  input wire logic       busWr,      // write select
  input wire logic [3:0] busAddr,    // offset
  input wire logic [7:0] busWdata,   // write data
  input wire logic [7:0] busRdata,   // read data
  input wire logic       ctlWr,      // control strobe
  input wire logic [7:0] ctlWdata,   // control data
  input wire logic [7:0] ctlRdata,   // control contents
  input wire logic       causeClr,   // cause clear
  input wire logic       causeWdog,  // reset cause
  input wire logic       haltReq,    // halt pulse
  input wire logic       boardReset, // board reset
  input wire logic       wdIrqA,     // line a
  input wire logic       wdIrqB      // line b
);
  logic [7:0]  cmdSh_r;     // shadow of command writes
  logic [31:0] sinceHalt_r; // cycles since halt
  logic [31:0] quiet_r;     // cycles since access
  wire         irqLine   = cmdSh_r[6] ? wdIrqB : wdIrqA;
  wire         otherLine = cmdSh_r[6] ? wdIrqA : wdIrqB;

  // shadow and cycle counters
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmdSh_r     <= 8'h00;
      sinceHalt_r <= 32'h0;
      quiet_r     <= 32'h0;
    end else begin
      if (busSel && busWr && busAddr == 4'hB) cmdSh_r <= busWdata;
      sinceHalt_r <= haltReq ? 32'h0 : sinceHalt_r + 32'h1;
      quiet_r     <= busSel ? 32'h0 : quiet_r + 32'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_pulse;
    irqLine == cmdSh_r[5] ##1 irqLine == !cmdSh_r[5];
  endsequence
  sequence s_hold16;
    boardReset [*8] ##1 boardReset [*8] ##1 !boardReset;
  endsequence

  a_read_idle_zero: assert property (!$past(busSel && !busWr) |-> busRdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_cmd_unused_zero: assert property ($past(busSel && !busWr && busAddr == 4'hB) |->
    busRdata[0] == 1'b0 && busRdata[2] == 1'b0) else $error("unused command bits read set");
  a_halt_one_cycle: assert property (haltReq |=> !haltReq)
    else $error("halt request longer than one cycle");
  a_halt_after_quiet: assert property (haltReq |-> !$past(busSel) && quiet_r >= 32'(STEP_CYC - 1))
    else $error("halt soon after an access");
  a_pulse_irq_shape: assert property (haltReq && cmdSh_r[4] |=> s_pulse)
    else $error("pulse interrupt shape wrong");
  a_level_irq_on: assert property (haltReq && !cmdSh_r[4] |=> irqLine == cmdSh_r[5])
    else $error("level interrupt not asserted");
  a_other_line_idle: assert property ($past(cmdSh_r, 2) == cmdSh_r |-> otherLine == !cmdSh_r[5])
    else $error("unselected interrupt line not idle");
  a_reset_delay_ok: assert property ($rose(boardReset) |->
    sinceHalt_r + 32'h3 >= 32'(HALT_CYC) && sinceHalt_r <= 32'(HALT_CYC + 3)) else $error("reset delay wrong");
  a_reset_hold_16: assert property ($rose(boardReset) |-> s_hold16)
    else $error("board reset width wrong");
  a_reset_needs_en: assert property ($rose(boardReset) |-> $past(ctlRdata[0], 2))
    else $error("board reset without enable");
  a_reset_clears_ctl: assert property ($rose(boardReset) |-> ##[1:3] ctlRdata == 8'h00)
    else $error("control not cleared by reset");
  a_reset_sets_cause: assert property ($rose(boardReset) |-> ##[0:2] causeWdog)
    else $error("reset cause not recorded");
endmodule

bind wdrt_top wdrt_top_sva #(.STEP_CYC(STEP_CYC), .HALT_CYC(HALT_CYC)) u_sva (
  .mclk(mclk), .rst(rst), .busSel(busSel), .busWr(busWr), .busAddr(busAddr), .busWdata(busWdata),
  .busRdata(busRdata), .ctlWr(ctlWr), .ctlWdata(ctlWdata), .ctlRdata(ctlRdata), .causeClr(causeClr),
  .causeWdog(causeWdog), .haltReq(haltReq), .boardReset(boardReset), .wdIrqA(wdIrqA), .wdIrqB(wdIrqB));

// *** tb/tb_wdrt_top.sv ***
`timescale 1ns/1ps
// drives the watchdog through its strobes and checks the outputs
module tb_wdrt_top;
  localparam int STEP = 20;  // short count step
  localparam int HALT = 50;  // short halt delay
  logic       mclk, rst, busSel, busWr, ctlWr, causeClr;
  logic [3:0] busAddr;
  logic [7:0] busWdata, busRdata, ctlWdata, ctlRdata, rd;
  logic       causeWdog, haltReq, boardReset, wdIrqA, wdIrqB;
  int         fail_count = 0, n_compared = 0, cyc, halts = 0, h0;

  wdrt_top #(.STEP_CYC(STEP), .HALT_CYC(HALT)) dut (
    .mclk(mclk), .rst(rst), .busSel(busSel), .busWr(busWr), .busAddr(busAddr), .busWdata(busWdata),
    .busRdata(busRdata), .ctlWr(ctlWr), .ctlWdata(ctlWdata), .ctlRdata(ctlRdata), .causeClr(causeClr),
    .causeWdog(causeWdog), .haltReq(haltReq), .boardReset(boardReset), .wdIrqA(wdIrqA), .wdIrqB(wdIrqB));

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one strobe, read data taken the cycle after
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    busSel = 1'b1;
    busWr = wr;
    busAddr = a;
    busWdata = d;
    @(negedge mclk);
    busSel = 1'b0;
    rd = busRdata;
  endtask

  // pulse on a one-cycle strobe of the control register
  task automatic ctl(input logic [7:0] d);
    @(negedge mclk);
    ctlWr = 1'b1;
    ctlWdata = d;
    @(negedge mclk);
    ctlWr = 1'b0;
    @(negedge mclk);
  endtask

  // wait for a halt request, counting cycles
  task automatic wait_halt(input int lim);
    cyc = 0;
    while (haltReq !== 1'b1 && cyc < lim) begin
      @(negedge mclk);
      cyc++;
    end
  endtask

  // count board reset cycles over a span
  task automatic count_rst(input int span);
    cyc = 0;
    repeat (span) begin
      @(negedge mclk);
      if (boardReset !== 1'b0) cyc++;
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) if (haltReq === 1'b1) halts <= halts + 1;

  // hang guard well past the expected run
  initial begin
    #400000;
    fail_count++;
    wrap_up;
  end

  initial begin
    {rst, busSel, busWr, ctlWr, causeClr} = 5'b10000;
    busAddr = 4'h0;
    busWdata = 8'h00;
    ctlWdata = 8'h00;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk("ctl reset", 8'h00, ctlRdata);
    chk("irq idle", 2'b11, {wdIrqA, wdIrqB});
    for (int a = 11; a < 15; a++) begin
      acc(1'b0, a[3:0], 8'h00);
      chk("reset read", 8'h00, rd);
    end
    // field mask, unmapped place and timeout bytes
    acc(1'b1, 4'hB, 8'hFF);
    acc(1'b0, 4'hB, 8'h00);
    chk("cmd fields", 8'hFA, rd);
    acc(1'b1, 4'hE, 8'h5A);
    acc(1'b0, 4'hE, 8'h00);
    chk("unmapped", 8'h00, rd);
    acc(1'b1, 4'hC, 8'h00);
    acc(1'b1, 4'hD, 8'h01);
    acc(1'b0, 4'hD, 8'h00);
    chk("timeout hi", 8'h01, rd);
    // 1.00 s borrows across both bytes; level, active low, line a, no board enable
    acc(1'b1, 4'hB, 8'h08);
    wait_halt(3000);
    chk("halt time", 1, cyc >= 100 * STEP - 3 && cyc <= 100 * STEP + 6);
    @(negedge mclk);
    chk("level irq", 1'b0, wdIrqA);
    acc(1'b0, 4'hB, 8'h00);
    chk("flag set", 8'h0A, rd);
    count_rst(HALT + 20);
    chk("no reset unarmed", 0, cyc);
    acc(1'b1, 4'hB, 8'h08);
    repeat (2) @(negedge mclk);
    chk("irq cleared", 1'b1, wdIrqA);
    // periodic reads keep a 0.10 s timeout from running out
    acc(1'b1, 4'hC, 8'h10);
    acc(1'b1, 4'hD, 8'h00);
    h0 = halts;
    repeat (6) begin
      repeat (150) @(negedge mclk);
      acc(1'b0, 4'hC, 8'h00);
    end
    chk("kept alive", h0, halts);
    wait_halt(400);
    chk("halt after read", 1, cyc >= 10 * STEP - 3 && cyc <= 10 * STEP + 6);
    // let the halt wait of that expiry run out before arming the board
    repeat (HALT + 5) @(negedge mclk);
    // armed board reset: pulse, active high, line b; enable set last
    acc(1'b1, 4'hC, 8'h01);
    acc(1'b1, 4'hB, 8'h78);
    ctl(8'h01);
    chk("ctl set", 8'h01, ctlRdata);
    wait_halt(100);
    @(negedge mclk);
    chk("pulse irq", 2'b01, {wdIrqA, wdIrqB});
    @(negedge mclk);
    chk("pulse end", 2'b00, {wdIrqA, wdIrqB});
    cyc = 0;
    while (boardReset !== 1'b1 && cyc < 200) begin
      @(negedge mclk);
      cyc++;
    end
    chk("reset delay", 1, cyc >= HALT - 6 && cyc <= HALT + 2);
    count_rst(30);
    chk("reset width", 16, cyc + 1);
    chk("ctl cleared", 8'h00, ctlRdata);
    chk("cause set", 1'b1, causeWdog);
    @(negedge mclk);
    causeClr = 1'b1;
    @(negedge mclk);
    causeClr = 1'b0;
    @(negedge mclk);
    chk("cause cleared", 1'b0, causeWdog);
    // second expiry after the one reset: halt only
    acc(1'b1, 4'hB, 8'h78);
    wait_halt(100);
    chk("halt again", 1'b1, haltReq);
    count_rst(HALT + 20);
    chk("one shot", 0, cyc);
    // reset in mid run clears the board enable
    ctl(8'h01);
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    chk("enable after reset", 8'h00, ctlRdata);
    wrap_up;
  end
endmodule
